// >>> core/rmsw_pkg.sv
/*
  Constants for the redundant master switchover unit.
  Assumes a single 20 MHz clock and a synchronous active-high reset.
*/
package rmsw_pkg;
  // Clock period in ns
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Lamp flash half period in ms, and its cycle count
  localparam int unsigned FLASH_HALF_MS   = 250;
  localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // Communication loss timeout in ms, and its cycle count
  localparam int unsigned COMM_TMO_MS     = 100;
  localparam int unsigned COMM_TMO_CYC    = COMM_TMO_MS * 1000000 / CLK_PERIOD_NS;
  // Presence timeout for the copy exchange in ms, and its cycle count
  localparam int unsigned PRES_TMO_MS     = 500;
  localparam int unsigned PRES_TMO_CYC    = PRES_TMO_MS * 1000000 / CLK_PERIOD_NS;
  // Counter width for all timers
  localparam int unsigned TMR_W           = 32;
  // Role line levels
  localparam logic        ROLE_ACTIVE     = 1'h0;
  localparam logic        ROLE_STANDBY    = 1'h1;
  // Copy path width
  localparam int unsigned COPY_W          = 8;
  // Version field width
  localparam int unsigned VER_W           = 8;
  // Index of each master
  localparam logic        SEL_FIRST       = 1'h0;
  localparam logic        SEL_SECOND      = 1'h1;

  // Selection state: which master owns the bus
  typedef enum logic [1:0] {
    RMSW_ST_FIRST  = 2'h0,
    RMSW_ST_SWAP   = 2'h1,
    RMSW_ST_SECOND = 2'h3
  } rmsw_state_t;
endpackage

// >>> core/rmsw_timer.sv
/*
  Retriggerable timeout counter: expires when no kick arrives for LIMIT cycles.
  Assumes the kick comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rmsw_timer
  import rmsw_pkg::*;
#(
  parameter int unsigned LIMIT = 16
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_kick,
  output logic      o_expired
);
  logic [TMR_W-1:0] cnt_reg; // Cycles since last kick

  ////////////////////////////////////////////////////////////////////////////
  // Count up while idle, restart on kick
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_kick)
    begin
      cnt_reg   <= '0;
      o_expired <= 1'h0;
    end
    else if (cnt_reg >= TMR_W'(LIMIT - 1))
    begin
      o_expired <= 1'h1; // Holds until next kick
    end
    else
    begin
      cnt_reg <= cnt_reg + TMR_W'(1);
    end
  end
endmodule
`default_nettype wire

// >>> core/rmsw_core.sv
/*
  Redundant master switchover unit: routes the slave bus to one of two
  masters, drives role lines, copies the process image, drives two lamps.
  Assumes request, presence and activity inputs come from other clock
  domains; bus mux is a select output to external transceiver switching.
*/
// Function
// R1: Slave bus joins exactly one master
// R2: One role output, one request input per master
// R3: Role line low active, high standby
// R4: Request rising edge swaps if other present
// R5: Lost slave traffic fails over automatically
// R6: Former standby becomes active after failover
// R7: Copy image and parameters active to standby
// R8: Copy exchange detects and records present masters
// R9: Tool content is never copied over
// R10: Firmware updates are never relayed
// R11: Lamp one steady while master one active
// R12: Lamp two steady while master two active
// R13: Flash lamp of absent or faulty master; code flashes only an absent master's lamp
// R14: Alternate flashing on version mismatch
// R15: Requests synchronised before edge detection
// R16: Flash period and timeout are parameters
`timescale 1ns/1ps
`default_nettype none
module rmsw_core
  import rmsw_pkg::*;
#(
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC, // Lamp half period [R16]
  parameter int unsigned COMM_CYC  = COMM_TMO_CYC,   // Bus loss timeout [R16]
  parameter int unsigned PRES_CYC  = PRES_TMO_CYC    // Presence timeout
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [1:0]        i_request,     // Request line from each master
  input  wire logic              i_bus_activity, // Slave frame seen, async
  input  wire logic [1:0]        i_copy_ack,    // Master answered the copy, async
  input  wire logic [VER_W-1:0]  i_first_master_port_ver,
  input  wire logic [VER_W-1:0]  i_second_master_port_ver,
  input  wire logic              i_copy_valid,  // Image word from active master
  input  wire logic [COPY_W-1:0] i_copy_data,   // Image or parameter word
  input  wire logic              i_copy_is_tool, // Word carries tool content
  input  wire logic              i_copy_is_fw,  // Word carries firmware
  output logic [1:0]             o_role,        // Role line to each master
  output logic                   o_bus_sel,     // 0 first, 1 second master
  output logic                   o_copy_valid,  // Word to standby master
  output logic [COPY_W-1:0]      o_copy_data,   // Forwarded word
  output logic [1:0]             o_present,     // Detected masters
  output logic [1:0]             o_lamp         // Status lamps
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] req_s1_reg;  // First stage, read only by second
  logic [1:0] req_s2_reg;  // Synchronised request
  logic [1:0] req_d_reg;   // Delayed for edge detection
  logic       act_s1_reg;  // First stage of activity
  logic       act_s2_reg;  // Synchronised activity
  logic [1:0] ack_s1_reg;  // First stage of copy answers
  logic [1:0] ack_s2_reg;  // Synchronised copy answers

  // Two flip-flops on every foreign input
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      req_s1_reg <= 2'h0;
      req_s2_reg <= 2'h0;
      req_d_reg  <= 2'h0;
      act_s1_reg <= 1'h0;
      act_s2_reg <= 1'h0;
      ack_s1_reg <= 2'h0;
      ack_s2_reg <= 2'h0;
    end
    else
    begin
      req_s1_reg <= i_request;  // [R15]
      req_s2_reg <= req_s1_reg; // [R15]
      req_d_reg  <= req_s2_reg;
      act_s1_reg <= i_bus_activity;
      act_s2_reg <= act_s1_reg;
      ack_s1_reg <= i_copy_ack;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  logic [1:0] req_rise; // One pulse per rising edge [R15]
  assign req_rise = req_s2_reg & ~req_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Timers: slave traffic watchdog and per-master presence
  logic       comm_lost;  // Active master lost its slaves
  logic [1:0] pres_tmo;   // Master did not answer the copy exchange
  logic       comm_kick;  // Restart watchdog
  logic       state_is_swap;

  assign comm_kick = act_s2_reg | state_is_swap;

  rmsw_timer #(.LIMIT(COMM_CYC)) u_comm_tmr (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_kick    (comm_kick),
    .o_expired (comm_lost)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pres
      rmsw_timer #(.LIMIT(PRES_CYC)) u_pres_tmr (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_kick    (ack_s2_reg[gi]),
        .o_expired (pres_tmo[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Presence record from the copy exchange
  logic [1:0] present_reg; // Masters seen answering

  // An answer sets presence, a timeout clears it; the answer wins
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      present_reg <= 2'h0;
    end
    else
    begin
      present_reg <= ack_s2_reg | (present_reg & ~pres_tmo); // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection state machine
  rmsw_state_t state_reg;  // Current owner
  logic        target_reg; // Owner to take after the swap state
  logic        active;     // Index of the active master
  logic        other;      // Index of the standby master

  assign active        = (state_reg == RMSW_ST_SECOND) ? SEL_SECOND : SEL_FIRST;
  assign other         = ~active;
  assign state_is_swap = (state_reg == RMSW_ST_SWAP);

  // Swap on request or on loss, only toward a present master
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg  <= RMSW_ST_FIRST;
      target_reg <= SEL_FIRST;
    end
    else
    begin
      case (state_reg)
        RMSW_ST_FIRST,
        RMSW_ST_SECOND:
        begin
          if ((req_rise[active] || comm_lost) && present_reg[other]) // [R4] [R5]
          begin
            state_reg  <= RMSW_ST_SWAP;
            target_reg <= other; // [R6]
          end
        end
        RMSW_ST_SWAP:
        begin
          // One cycle with both roles standby before the new owner takes over
          state_reg <= (target_reg == SEL_SECOND) ? RMSW_ST_SECOND : RMSW_ST_FIRST; // [R6]
        end
        default:
        begin
          state_reg <= RMSW_ST_FIRST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Role lines and bus select
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_role    <= {ROLE_STANDBY, ROLE_ACTIVE};
      o_bus_sel <= SEL_FIRST;
    end
    else
    begin
      // Select holds through the swap cycle, so both roles go standby before it moves
      if (!state_is_swap)
      begin
        o_bus_sel <= active; // [R1]
      end
      if (state_is_swap)
      begin
        o_role <= {ROLE_STANDBY, ROLE_STANDBY};
      end
      else if (active == SEL_SECOND)
      begin
        o_role <= {ROLE_ACTIVE, ROLE_STANDBY}; // [R3] [R2]
      end
      else
      begin
        o_role <= {ROLE_STANDBY, ROLE_ACTIVE}; // [R3] [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image copy from active to standby master
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_copy_valid <= 1'h0;
      o_copy_data  <= '0;
    end
    else
    begin
      // Only process image and parameters pass; tool and firmware stay [R9] [R10]
      o_copy_valid <= i_copy_valid && !i_copy_is_tool && !i_copy_is_fw
                      && !state_is_swap; // [R7] [R9] [R10]
      o_copy_data  <= i_copy_data; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash timebase
  logic [TMR_W-1:0] flash_cnt_reg; // Half period counter
  logic             flash_reg;     // Flash phase

  // Toggle the phase every half period [R16]
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'h0;
    end
    else if (flash_cnt_reg >= TMR_W'(FLASH_CYC - 1))
    begin
      flash_cnt_reg <= '0;
      flash_reg     <= ~flash_reg; // [R16]
    end
    else
    begin
      flash_cnt_reg <= flash_cnt_reg + TMR_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presence output and lamps
  logic ver_mismatch; // Versions differ while both present
  assign ver_mismatch = (present_reg == 2'h3)
                        && (i_first_master_port_ver != i_second_master_port_ver);

  // Mismatch first, then per-master error, then steady active lamp
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_present <= 2'h0;
      o_lamp    <= 2'h0;
    end
    else
    begin
      o_present <= present_reg; // [R8]
      if (ver_mismatch)
      begin
        o_lamp <= {~flash_reg, flash_reg}; // [R14]
      end
      else
      begin
        // Absent master flashes, else its lamp shows active [R13]
        o_lamp[0] <= !present_reg[0] ? flash_reg
                                     : (active == SEL_FIRST);  // [R13] [R11]
        o_lamp[1] <= !present_reg[1] ? flash_reg
                                     : (active == SEL_SECOND); // [R13] [R12]
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/rmsw_core_props.sv
/* Port checker for the switchover unit.
   Assumes bind onto rmsw_core, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module rmsw_core_props
  import rmsw_pkg::*;
#(
  parameter int unsigned FLASH_CYC = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_request,
  input wire logic [VER_W-1:0] i_first_master_port_ver,
  input wire logic [VER_W-1:0] i_second_master_port_ver,
  input wire logic i_copy_valid,
  input wire logic [COPY_W-1:0] i_copy_data,
  input wire logic i_copy_is_tool,
  input wire logic i_copy_is_fw,
  input wire logic [1:0] o_role,
  input wire logic o_bus_sel,
  input wire logic o_copy_valid,
  input wire logic [COPY_W-1:0] o_copy_data,
  input wire logic [1:0] o_present,
  input wire logic [1:0] o_lamp
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic ver_eq = i_first_master_port_ver == i_second_master_port_ver; // Same software
  int unsigned still_cnt; // Cycles lamp two held while master two absent
  // Counts how long lamp two stays put while master two is absent
  always_ff @(posedge i_clk)
  begin
    if (i_rst || o_present[1] || o_lamp[1] != $past(o_lamp[1]))
      still_cnt <= 0;
    else
      still_cnt <= still_cnt + 1;
  end
  a_reset_values: assert property ($fell(i_rst) |-> o_role == 2'b10 && !o_bus_sel
    && o_present == 2'h0 && o_lamp == 2'h0 && !o_copy_valid) else $error("reset values");
  a_one_owner: assert property (o_role != 2'b00) else $error("two owners");
  a_role_owner: assert property (o_role != 2'h3
    |-> o_role == (o_bus_sel ? 2'h1 : 2'h2)) else $error("role and select disagree");
  a_break_first: assert property ($changed(o_bus_sel) |-> $past(o_role) == 2'b11)
    else $error("no break before make");
  a_req_swap: assert property ($rose(i_request[0]) && o_role == 2'b10 && o_present[1]
    |-> ##[3:8] o_bus_sel) else $error("request not served");
  a_absent_hold: assert property (!o_present[1] [*4] |-> !$rose(o_bus_sel))
    else $error("swap to absent master");
  a_copy_fwd: assert property ((i_copy_valid && !i_copy_is_tool && !i_copy_is_fw)
    ##1 (o_role != 2'h3) |-> o_copy_valid && o_copy_data == $past(i_copy_data))
    else $error("copy lost");
  a_copy_drop: assert property (!i_copy_valid || i_copy_is_tool || i_copy_is_fw
    |=> !o_copy_valid) else $error("copy not dropped");
  a_lamp_first: assert property ((o_role == 2'b10 && o_present == 2'b11 && ver_eq) [*3]
    |-> o_lamp == 2'b01) else $error("lamp one");
  a_lamp_second: assert property ((o_role == 2'b01 && o_present == 2'b11 && ver_eq) [*3]
    |-> o_lamp == 2'b10) else $error("lamp two");
  a_lamp_alt: assert property ((o_present == 2'h3 && !ver_eq) [*3]
    |-> o_lamp[0] != o_lamp[1]) else $error("lamps not alternate");
  a_absent_flash: assert property (still_cnt <= FLASH_CYC + 1)
    else $error("lamp two stuck");
  c_to_second: cover property ($rose(o_bus_sel));
  c_to_first: cover property ($fell(o_bus_sel));
  c_mismatch: cover property (o_present == 2'b11 && !ver_eq);
endmodule
`default_nettype wire

// >>> verif/rmsw_master_model.sv
/* Model of both master controllers: copy answers and request lines.
   Assumes the bench says which masters run and which request. */
`timescale 1ns/1ps
`default_nettype none
module rmsw_master_model
(
  input wire logic [1:0] i_alive,   // Master powered and running
  input wire logic [1:0] i_req_cmd, // Bench asks for a request level
  input wire logic       i_clk,
  output logic     [1:0] o_ack,     // Copy exchange answer
  output logic     [1:0] o_req      // Request line to the unit
);
  logic [1:0] ph; // Answer pacing, one answer every four cycles
  initial
  begin
    ph = 2'h0;
    o_ack = 2'h0;
    o_req = 2'h0;
  end
  // One line each way per master; a dead master answers nothing
  always @(posedge i_clk)
  begin
    ph <= ph + 2'h1;
    o_ack <= i_alive & {2{ph == 2'h0}};
    o_req <= i_req_cmd & i_alive;
  end
endmodule
`default_nettype wire

// >>> verif/test_rmsw_core.sv
/* Bench for the switchover unit with both masters modelled.
   Assumes short timers: flash 8, loss 20, presence 40 cycles. */
`timescale 1ns/1ps
`default_nettype none
module test_rmsw_core;
  logic clk, rst, act_en, act, cv, tool, fw, sel, ocv, seen0, seen1;
  logic [1:0] alive, req_cmd, ack, req, role, lamp, pres;
  logic [7:0] v1, v2, cd, ocd;
  int errors, total_checks, seed, i;
  rmsw_core #(.FLASH_CYC(8), .COMM_CYC(20), .PRES_CYC(40)) u_rmsw_core (.i_clk(clk),
    .i_rst(rst), .i_request(req), .i_bus_activity(act), .i_copy_ack(ack),
    .i_first_master_port_ver(v1), .i_second_master_port_ver(v2), .i_copy_valid(cv),
    .i_copy_data(cd), .i_copy_is_tool(tool), .i_copy_is_fw(fw), .o_role(role),
    .o_bus_sel(sel), .o_copy_valid(ocv), .o_copy_data(ocd), .o_present(pres), .o_lamp(lamp));
  rmsw_master_model u_rmsw_master_model (.i_clk(clk), .i_alive(alive),
    .i_req_cmd(req_cmd), .o_ack(ack), .o_req(req));
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Bounded wait for the select (w=0) or presence of master two (w=1)
  task automatic wait_for(input int w, input logic e);
    for (int k = 0; k < 90 && (w ? pres[1] : sel) !== e; k++)
      step(1);
    if ((w ? pres[1] : sel) !== e)
    begin
      errors++;
      wrap_up();
    end
  endtask
  // Watches lamp b for both phases over twenty cycles
  task automatic scan(input int b, input logic alt);
    {seen0, seen1} = 2'b00;
    for (int k = 0; k < 20; k++)
    begin
      seen1 |= lamp[b];
      seen0 |= ~lamp[b];
      chk("lamp", 8'(alt ? lamp[0] ^ lamp[1] : lamp[0]), 8'h01);
      step(1);
    end
    chk("flash", {6'h0, seen0, seen1}, 8'h03);
  endtask
  function automatic logic fwd(input logic t, input logic f);
    return !(t || f);
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Slave traffic toggles while enabled
  always @(posedge clk)
    #5 act = act_en & ~act;
  initial
  begin
    rst = 1'b1;
    {act_en, cv, tool, fw, req_cmd, cd} = '0;
    {v1, v2, alive} = {8'h21, 8'h21, 2'b11};
    {errors, total_checks, seed} = {32'h0, 32'h0, 32'h3529};
    step(20);
    chk("reset", {role, lamp, pres, 1'b0, sel}, 8'h80);
    {rst, act_en} = 2'b01;
    step(16);
    chk("present", 8'(pres), 8'h03);
    chk("lamps", {role, 4'h0, lamp}, 8'h81);
    for (i = 0; i < 24; i++)
    begin
      cv = 1'b1;
      cd = 8'($random(seed));
      tool = ($random(seed) & 3) == 0;
      fw = ($random(seed) & 3) == 1;
      step(1);
      chk("copy_valid", 8'(ocv), 8'(fwd(tool, fw)));
      if (fwd(tool, fw))
        chk("copy_data", ocd, cd);
    end
    cv = 1'b0;
    req_cmd = 2'b01;
    wait_for(0, 1'b1);
    step(4);
    chk("swap", {role, 4'h0, lamp}, 8'h42);
    step(12);
    req_cmd = 2'b00;
    step(4);
    req_cmd = 2'b01;
    step(12);
    chk("held", 8'(sel), 8'h01);
    // Active second master asks, bus returns to the first, then first asks again
    req_cmd = 2'b10;
    wait_for(0, 1'b0);
    chk("back", 8'(role), 8'h02);
    req_cmd = 2'b01;
    wait_for(0, 1'b1);
    req_cmd = 2'b00;
    act_en = 1'b0;
    wait_for(0, 1'b0);
    chk("failover", 8'(role), 8'h02);
    act_en = 1'b1;
    v2 = 8'h22;
    step(4);
    scan(0, 1'b1);
    v2 = 8'h21;
    alive = 2'b01;
    wait_for(1, 1'b0);
    step(3);
    scan(1, 1'b0);
    {req_cmd, act_en} = 3'b010;
    step(40);
    chk("refused", 8'(sel), 8'h00);
    wrap_up();
  end
endmodule
bind rmsw_core rmsw_core_props #(.FLASH_CYC(FLASH_CYC)) u_rmsw_core_props (.i_clk(i_clk),
  .i_rst(i_rst), .i_request(i_request), .i_first_master_port_ver(i_first_master_port_ver),
  .i_second_master_port_ver(i_second_master_port_ver), .i_copy_valid(i_copy_valid),
  .i_copy_data(i_copy_data), .i_copy_is_tool(i_copy_is_tool), .i_copy_is_fw(i_copy_is_fw),
  .o_role(o_role), .o_bus_sel(o_bus_sel), .o_copy_valid(o_copy_valid),
  .o_copy_data(o_copy_data), .o_present(o_present), .o_lamp(o_lamp));
`default_nettype wire
